// ==== rtl/lts_map.vh ====
// Behaviour
// [RQ1] beacon is sent on the link while the beacon request is held high
// [RQ2] scramble-off request sets the disable-scrambling bit in sent training sets
// [RQ3] disable request moves the machine from Config or Recovery to Disabled
// [RQ4] detect request moves the machine from L2 or Disabled to Detect
// [RQ5] hot-reset request moves the machine from Recovery to Hot Reset
// [RQ6] L0s entry request moves the machine from L0 to L0s
// [RQ7] L0s exit request in L0s sends fast training sequences, then back to L0
// [RQ8] L1 request moves the machine from L0 to L1
// [RQ9] L2 request moves the machine from L0 to L2
// [RQ10] any loopback request bit moves the machine from Config or Recovery to Loopback
// [RQ11] recovery request moves the machine from L0, L0s or L1 to Recovery
// [RQ12] config request moves the machine from Recovery to Config
// [RQ13] current state is reported as a four-bit code
// [RQ14] one active-high bit per lane shows inclusion in Config width negotiation
// [RQ15] inclusion vector is lane reversed: bit 0 is lane 3, bit 1 lane 2
// [RQ16] bit 2 reports lane 1 and bit 3 reports lane 0
// [RQ17] asynchronous scramble-off and disable requests pass two flip-flops first
// [RQ18] requests arriving in a state that does not permit them are ignored
// [RQ19] user logic holds each request until the state code shows arrival
`ifndef LTS_MAP_VH
`define LTS_MAP_VH

// ----------------------------------------
// state codes
// ----------------------------------------
`define LTS_ST_DETECT   4'h0
`define LTS_ST_POLLING  4'h1
`define LTS_ST_CONFIG   4'h2
`define LTS_ST_L0       4'h3
`define LTS_ST_L0S      4'h4
`define LTS_ST_L1       4'h5
`define LTS_ST_L2       4'h6
`define LTS_ST_RECOVERY 4'h7
`define LTS_ST_LOOPBACK 4'h8
`define LTS_ST_HOTRST   4'h9
`define LTS_ST_DISABLED 4'hA

// ----------------------------------------
// register map and fields
// ----------------------------------------
`define LTS_REG_CTRL    4'h0
`define LTS_REG_STATUS  4'h4
`define LTS_CTRL_BEACON 0
`define LTS_CTRL_SCROFF 1
`define LTS_CTRL_MASK_LSB 4
`define LTS_CTRL_RESET  32'h0000_00F0

// ----------------------------------------
// timing counts in clock cycles
// ----------------------------------------
`define LTS_STEP_CYCLES 16'h0010

`endif

// ==== rtl/lts_ctrl.v ====
`default_nettype none
`include "lts_map.vh"

module lts_ctrl #(
  parameter LANES       = 4,
  parameter STEP_CYCLES = `LTS_STEP_CYCLES
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             beacon_send_req,
  input  wire             scramble_off_req,
  input  wire             goto_disabled_req,
  input  wire             goto_detect_req,
  input  wire             goto_hot_reset_req,
  input  wire             enter_l0s_tx_req,
  input  wire             exit_l0s_fts_req,
  input  wire             goto_l1_req,
  input  wire             goto_l2_req,
  input  wire [3:0]       goto_loopback_req,
  input  wire             goto_recovery_req,
  input  wire             goto_config_req,
  input  wire [LANES-1:0] lane_rx_present,
  output reg  [3:0]       ltssm_state_q,
  output reg  [LANES-1:0] lane_incl_q,
  output reg              beacon_tx_q,
  output reg              ts_scramble_off_q,
  output reg              fts_tx_q,
  input  wire [3:0]       avs_address,
  input  wire             avs_read,
  input  wire             avs_write,
  input  wire [31:0]      avs_writedata,
  output reg  [31:0]      avs_readdata,
  output wire             avs_waitrequest
);

  // ----------------------------------------
  // synchronisers for asynchronous inputs
  // ----------------------------------------
  reg [LANES+1:0] sync1_q;
  reg [LANES+1:0] sync2_q;
  wire            scr_off_s;
  wire            dis_s;
  wire [LANES-1:0] present_s;

  // two flops, first stage read only by second
  always @(posedge clk)
  begin
    if (reset)
    begin
      sync1_q <= {(LANES+2){1'b0}};
      sync2_q <= {(LANES+2){1'b0}};
    end
    else
    begin
      sync1_q <= {lane_rx_present, goto_disabled_req, scramble_off_req}; // RQ17
      sync2_q <= sync1_q; // RQ17
    end
  end

  assign scr_off_s = sync2_q[0];
  assign dis_s     = sync2_q[1];
  assign present_s = sync2_q[LANES+1:2];

  // ----------------------------------------
  // register file
  // ----------------------------------------
  reg [31:0]       ctrl_q;
  reg              ack_q;
  reg [3:0]        incl_word;
  wire             access;
  wire [LANES-1:0] lane_mask;

  // one wait cycle per access, answer at the second edge
  assign access          = avs_read | avs_write;
  assign avs_waitrequest = access & ~ack_q;
  assign lane_mask       = ctrl_q[`LTS_CTRL_MASK_LSB +: LANES];

  // lane report padded to a full nibble for the status word
  always @*
  begin
    incl_word            = 4'h0;
    incl_word[LANES-1:0] = lane_incl_q;
  end

  // acknowledge flop, high in the cycle waitrequest drops
  always @(posedge clk)
  begin
    if (reset)
      ack_q <= 1'b0;
    else
      ack_q <= access & ~ack_q;
  end

  // read data loaded in the wait cycle, stands until next access
  always @(posedge clk)
  begin
    if (reset)
      avs_readdata <= 32'h0000_0000;
    else if (access & ~ack_q)
    begin
      case (avs_address)
        `LTS_REG_CTRL:
          avs_readdata <= ctrl_q;
        `LTS_REG_STATUS:
          avs_readdata <= {21'h0,             // unused
                           fts_tx_q,          // fast training
                           ts_scramble_off_q, // scramble off
                           beacon_tx_q,       // beacon
                           incl_word,         // lane report
                           ltssm_state_q};    // state code
        default:
          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // control word lands at the edge that ends the write
  always @(posedge clk)
  begin
    if (reset)
      ctrl_q <= `LTS_CTRL_RESET;
    else if (avs_write & ack_q & (avs_address == `LTS_REG_CTRL))
      ctrl_q <= avs_writedata;
  end

  // ----------------------------------------
  // training state machine
  // ----------------------------------------
  reg [15:0] step_q;
  reg [3:0]  state_d;
  wire       step_done;

  // step timer expiry, shared by every timed exit
  assign step_done = (step_q == STEP_CYCLES[15:0] - 16'h0001);

  // next state; order of checks sets priority inside a state
  always @*
  begin
    state_d = ltssm_state_q;
    case (ltssm_state_q)
      `LTS_ST_DETECT:
      begin
        if (|(present_s & lane_mask))
          state_d = `LTS_ST_POLLING;
      end
      `LTS_ST_POLLING:
      begin
        if (step_done)
          state_d = `LTS_ST_CONFIG;
      end
      `LTS_ST_CONFIG:
      begin
        if (dis_s)
          state_d = `LTS_ST_DISABLED; // RQ3
        else if (|goto_loopback_req)
          state_d = `LTS_ST_LOOPBACK; // RQ10
        else if (step_done)
          state_d = `LTS_ST_L0;
      end
      `LTS_ST_L0:
      begin
        if (goto_recovery_req)
          state_d = `LTS_ST_RECOVERY; // RQ11
        else if (goto_l2_req)
          state_d = `LTS_ST_L2; // RQ9
        else if (goto_l1_req)
          state_d = `LTS_ST_L1; // RQ8
        else if (enter_l0s_tx_req)
          state_d = `LTS_ST_L0S; // RQ6
      end
      `LTS_ST_L0S:
      begin
        if (goto_recovery_req)
          state_d = `LTS_ST_RECOVERY; // RQ11
        else if (fts_tx_q & step_done)
          state_d = `LTS_ST_L0; // RQ7
      end
      `LTS_ST_L1:
      begin
        if (goto_recovery_req)
          state_d = `LTS_ST_RECOVERY; // RQ11
      end
      `LTS_ST_L2:
      begin
        if (goto_detect_req)
          state_d = `LTS_ST_DETECT; // RQ4
      end
      `LTS_ST_RECOVERY:
      begin
        if (dis_s)
          state_d = `LTS_ST_DISABLED; // RQ3
        else if (goto_hot_reset_req)
          state_d = `LTS_ST_HOTRST; // RQ5
        else if (|goto_loopback_req)
          state_d = `LTS_ST_LOOPBACK; // RQ10
        else if (goto_config_req)
          state_d = `LTS_ST_CONFIG; // RQ12
        else if (step_done)
          state_d = `LTS_ST_L0;
      end
      `LTS_ST_LOOPBACK:
      begin
        if (~|goto_loopback_req)
          state_d = `LTS_ST_DETECT;
      end
      `LTS_ST_HOTRST:
      begin
        if (step_done)
          state_d = `LTS_ST_DETECT;
      end
      `LTS_ST_DISABLED:
      begin
        if (goto_detect_req)
          state_d = `LTS_ST_DETECT; // RQ4
      end
      default:
        state_d = `LTS_ST_DETECT;
    endcase
    // any request not listed for the current state falls through unused  RQ18
  end

  // ----------------------------------------
  // state register and step timer
  // ----------------------------------------

  // state code register
  always @(posedge clk)
  begin
    if (reset)
      ltssm_state_q <= `LTS_ST_DETECT;
    else
      ltssm_state_q <= state_d; // RQ13
  end

  // step timer restarts on a state change and on expiry
  always @(posedge clk)
  begin
    if (reset)
      step_q <= 16'h0000;
    else if (state_d != ltssm_state_q || step_done)
      step_q <= 16'h0000;
    else
      step_q <= step_q + 16'h0001;
  end

  // ----------------------------------------
  // line controls
  // ----------------------------------------

  // fast training sequences only while staying in L0s
  always @(posedge clk)
  begin
    if (reset)
      fts_tx_q <= 1'b0;
    else if (state_d != `LTS_ST_L0S)
      fts_tx_q <= 1'b0;
    else if (exit_l0s_fts_req)
      fts_tx_q <= 1'b1; // RQ7
  end

  // beacon and scramble-off follow the request or the software bit
  always @(posedge clk)
  begin
    if (reset)
    begin
      beacon_tx_q       <= 1'b0;
      ts_scramble_off_q <= 1'b0;
    end
    else
    begin
      beacon_tx_q       <= beacon_send_req | ctrl_q[`LTS_CTRL_BEACON]; // RQ1
      ts_scramble_off_q <= scr_off_s | ctrl_q[`LTS_CTRL_SCROFF]; // RQ2
    end
  end

  // ----------------------------------------
  // lane report
  // ----------------------------------------

  // report live only while in Config, zero elsewhere
  always @(posedge clk)
  begin
    if (reset)
      lane_incl_q <= {LANES{1'b0}};
    else if (state_d == `LTS_ST_CONFIG)
      lane_incl_q <= rev_lanes(present_s & lane_mask); // RQ14
    else
      lane_incl_q <= {LANES{1'b0}};
  end

  // bit i reports lane LANES-1-i
  function [LANES-1:0] rev_lanes;
    input [LANES-1:0] v;
    integer i;
    begin
      for (i = 0; i < LANES; i = i + 1)
        rev_lanes[i] = v[LANES-1-i]; // RQ15 RQ16
    end
  endfunction

endmodule
`default_nettype wire

// ==== test/lts_monitor.sv ====
`default_nettype none
`include "lts_map.vh"
module lts_monitor (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       beacon_send_req,
  input wire logic       goto_detect_req,
  input wire logic       enter_l0s_tx_req,
  input wire logic       exit_l0s_fts_req,
  input wire logic       goto_l1_req,
  input wire logic       goto_l2_req,
  input wire logic       goto_recovery_req,
  input wire logic [3:0] ltssm_state_q,
  input wire logic       beacon_tx_q,
  input wire logic       fts_tx_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic [3:0] s = ltssm_state_q;
  wire logic       r = goto_recovery_req;
  // request to state moves, recovery wins in L0 and L0s
  a_beacon_out:
    assert property (beacon_send_req |=> beacon_tx_q) else $error("beacon missing");
  a_l1_entry:
    assert property (s == `LTS_ST_L0 && goto_l1_req && !r && !goto_l2_req |=> s == `LTS_ST_L1) else $error("no L1");
  a_l2_entry:
    assert property (s == `LTS_ST_L0 && goto_l2_req && !r |=> s == `LTS_ST_L2) else $error("no L2");
  a_l0s_entry:
    assert property (s == `LTS_ST_L0 && enter_l0s_tx_req && !(r | goto_l1_req | goto_l2_req) |=> s == `LTS_ST_L0S)
      else $error("no L0s");
  a_rec_entry:
    assert property (s inside {`LTS_ST_L0, `LTS_ST_L0S, `LTS_ST_L1} && r |=> s == `LTS_ST_RECOVERY)
      else $error("no recovery");
  a_fts_sent:
    assert property (s == `LTS_ST_L0S && exit_l0s_fts_req && !r |=> fts_tx_q || s == `LTS_ST_L0) else $error("no fts");
  a_det_entry:
    assert property (s == `LTS_ST_L2 && goto_detect_req |=> s == `LTS_ST_DETECT) else $error("no detect");
  a_l1_hold:
    assert property (s == `LTS_ST_L1 && !r |=> $stable(s)) else $error("left L1");
endmodule
bind lts_ctrl lts_monitor u_mon (.clk, .reset, .beacon_send_req, .goto_detect_req, .enter_l0s_tx_req,
  .exit_l0s_fts_req, .goto_l1_req, .goto_l2_req, .goto_recovery_req, .ltssm_state_q, .beacon_tx_q, .fts_tx_q);
`default_nettype wire

// ==== test/lts_user.sv ====
`default_nettype none
module lts_user (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic [3:0] sel,
  input  wire logic [3:0] want,
  input  wire logic [3:0] state,
  output var  logic [9:0] req_q
);
  // raise one request, hold it until the state code shows arrival
  always @(posedge clk)
  begin
    if (reset)
      req_q <= 10'h000;
    else if (start)
      req_q <= 10'h001 << sel;
    else if (state == want)
      req_q <= 10'h000;
  end
endmodule
`default_nettype wire

// ==== test/link_training_state_control_test.sv ====
`default_nettype none
`include "lts_map.vh"
module link_training_state_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset, beacon, scr, start, rd, wr, waitreq, btx, stx, ftx;
  logic [3:0]  sel, want, state, addr, lanes, incl;
  logic [9:0]  req;
  logic [31:0] wdata, rdata, got;
  int          n_errors, samples_checked, cyc;
  localparam int STEP = 12;
  lts_ctrl #(.STEP_CYCLES(STEP)) DUT (.clk, .reset, .beacon_send_req(beacon), .scramble_off_req(scr),
    .goto_disabled_req(req[0]), .goto_detect_req(req[1]), .goto_hot_reset_req(req[2]), .enter_l0s_tx_req(req[3]),
    .exit_l0s_fts_req(req[4]), .goto_l1_req(req[5]), .goto_l2_req(req[6]), .goto_loopback_req(req[7] ? 4'h4 : 4'h0),
    .goto_recovery_req(req[8]), .goto_config_req(req[9]), .lane_rx_present(lanes), .ltssm_state_q(state),
    .lane_incl_q(incl), .beacon_tx_q(btx), .ts_scramble_off_q(stx), .fts_tx_q(ftx), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitreq));
  lts_user u_user (.clk, .reset, .start, .sel, .want, .state, .req_q(req));
  // clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      n_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    while (waitreq !== 1'b0) @(posedge clk);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // ask the user model for a move and expect arrival within a few cycles
  task automatic go(input logic [3:0] s, w, input int lim = 9);
    int n = 0;
    @(posedge clk);
    sel <= s;
    want <= w;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    while (state !== w && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    chk(state, w);
  endtask
  task automatic wait_for(input logic [3:0] w);
    while (state !== w) @(posedge clk);
  endtask
  // main sequence
  initial
  begin
    reset = 1'b1;
    {beacon, scr, start, rd, wr, sel, want, addr, lanes, wdata} = '0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    bus(1'b0, `LTS_REG_STATUS, '0);
    chk(got, '0);
    bus(1'b0, `LTS_REG_CTRL, '0);
    chk(got, `LTS_CTRL_RESET);
    bus(1'b1, `LTS_REG_CTRL, 32'h0000_0050);
    bus(1'b0, 4'h8, '0);
    chk(got, '0);
    lanes <= 4'hF;
    wait_for(`LTS_ST_CONFIG);
    repeat (2) @(posedge clk);
    chk(incl, 4'hA);
    wait_for(`LTS_ST_L0);
    beacon <= 1'b1;
    scr <= 1'b1;
    repeat (4) @(posedge clk);
    chk({btx, stx}, 2'b11);
    beacon <= 1'b0;
    scr <= 1'b0;
    go(4'h5, `LTS_ST_L1);
    go(4'h6, `LTS_ST_L1);
    repeat (3) @(posedge clk);
    chk(state, `LTS_ST_L1);
    go(4'h8, `LTS_ST_RECOVERY);
    go(4'h9, `LTS_ST_CONFIG);
    go(4'h7, `LTS_ST_LOOPBACK);
    wait_for(`LTS_ST_CONFIG);
    go(4'h0, `LTS_ST_DISABLED);
    go(4'h1, `LTS_ST_DETECT);
    wait_for(`LTS_ST_L0);
    go(4'h6, `LTS_ST_L2);
    go(4'h1, `LTS_ST_DETECT);
    wait_for(`LTS_ST_L0);
    go(4'h3, `LTS_ST_L0S);
    // fts exit waits for the free running step timer to expire
    go(4'h4, `LTS_ST_L0, STEP + 8);
    go(4'h3, `LTS_ST_L0S);
    go(4'h8, `LTS_ST_RECOVERY);
    go(4'h2, `LTS_ST_HOTRST);
    summarize();
  end
endmodule
`default_nettype wire
